// ===== src/srif_spi_regs.sv
// serial peripheral register interface with baud divider and byte shift engine
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "srif_consts.svh"

module srif_spi_regs (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire srif_pkg::srif_apb_req_t apb_req,
    output srif_pkg::srif_apb_rsp_t      apb_rsp,
    input  wire srif_pkg::srif_pin_in_t  pin_in,
    output srif_pkg::srif_pin_out_t      pin_out,
    output srif_pkg::srif_irq_t          irq
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 rie;      // receive interrupt enable
        logic                 mstr;     // master select
        logic                 cpol;     // idle clock level
        logic                 cpha;     // clock phase
        logic                 wom;      // wired-or mode
        logic                 en;       // module enable
        logic                 tie;      // transmit interrupt enable
        logic                 erie;     // error interrupt enable
        logic                 mfen;     // mode fault enable
        logic [1:0]           spr;      // rate field
        logic                 rxf;      // receive full flag
        logic                 ovf;      // overflow flag
        logic                 mode_fault_flag;     // mode fault flag
        logic                 txe;      // transmit empty flag
        logic                 arm_rx;   // status seen with rxf/ovf set
        logic                 arm_mode_fault_flag; // status seen with mode_fault_flag set
        logic [7:0]           txbuf;    // transmit buffer
        logic [7:0]           rxbuf;    // receive buffer
        logic [7:0]           sr;       // outgoing shift register
        logic [7:0]           rsr;      // incoming shift register
        logic                 out_bit;  // bit on the data output
        logic                 sclk;     // master clock level
        logic [3:0]           edges;    // clock edges seen this byte
        logic [6:0]           cnt;      // half period countdown
        logic                 ss_prev;  // select level last cycle
        logic                 sclk_prev;// slave clock level last cycle
        srif_pkg::srif_xfer_t st;       // engine state
    } srif_state_t;

    localparam logic [7:0] CTL_RST = `SRIF_CTL_RST;
    localparam logic [7:0] STS_RST = `SRIF_STS_RST;

    // control and flag fields take their bits from the reset bytes
    // reset image of the whole state
    localparam srif_state_t RST_STATE = '{
        rie:      CTL_RST[`SRIF_CTL_RIE],
        mstr:     CTL_RST[`SRIF_CTL_MSTR],
        cpol:     CTL_RST[`SRIF_CTL_CPOL],
        cpha:     CTL_RST[`SRIF_CTL_CPHA],
        wom:      CTL_RST[`SRIF_CTL_WOM],
        en:       CTL_RST[`SRIF_CTL_EN],
        tie:      CTL_RST[`SRIF_CTL_TIE],
        erie:     STS_RST[`SRIF_STS_ERIE],
        mfen:     STS_RST[`SRIF_STS_MFEN],
        spr:      STS_RST[`SRIF_STS_SPR_HI:`SRIF_STS_SPR_LO],
        rxf:      STS_RST[`SRIF_STS_RXF],
        ovf:      STS_RST[`SRIF_STS_OVF],
        mode_fault_flag:     STS_RST[`SRIF_STS_MODE_FAULT_FLAG],
        txe:      STS_RST[`SRIF_STS_TXE],
        arm_rx:   1'b0,
        arm_mode_fault_flag: 1'b0,
        txbuf:    8'h00,
        rxbuf:    8'h00,
        sr:       8'h00,
        rsr:      8'h00,
        out_bit:  1'b0,
        sclk:     1'b0,
        edges:    4'h0,
        cnt:      7'h00,
        ss_prev:  1'b1,
        sclk_prev: 1'b0,
        st:       srif_pkg::SRIF_IDLE
    };

    srif_state_t s_ff;   // registered state
    srif_state_t nxt_s;  // next state

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // baud divisor for a rate field value
    function automatic logic [7:0] baud_div(input logic [1:0] spr);
        unique case (spr)
            2'b00: baud_div = `SRIF_BD_00;
            2'b01: baud_div = `SRIF_BD_01;
            2'b10: baud_div = `SRIF_BD_10;
            2'b11: baud_div = `SRIF_BD_11;
        endcase
    endfunction

    // drv low releases the pad; the level still follows for read-back
    // pin drive as {out, oe}; open drain only pulls low
    function automatic logic [1:0] pad(input logic lvl, input logic wom, input logic drv);
        if (!drv) begin
            pad = {lvl, 1'b0};
        end else if (wom) begin
            pad = {1'b0, ~lvl};
        end else begin
            pad = {lvl, 1'b1};
        end
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic       acc;       // access phase of a transfer
    logic       hit_ctl;   // control register addressed
    logic       hit_sts;   // status register addressed
    logic       hit_dat;   // data register addressed
    logic [7:0] rd_byte;   // read mux output
    logic [7:0] half_m1;   // half period count minus one

    // the half period is the divisor in pclk cycles; the countdown
    // reloads with one less because its zero cycle counts too
    // address decode and read mux over the flip-flops
    always_comb begin
        acc     = apb_req.psel && apb_req.penable;
        hit_ctl = (apb_req.paddr == `SRIF_ADDR_CONTROL);
        hit_sts = (apb_req.paddr == `SRIF_ADDR_STATUS);
        hit_dat = (apb_req.paddr == `SRIF_ADDR_DATA);
        half_m1 = baud_div(s_ff.spr) - 8'h01;
        rd_byte = 8'h00;
        if (hit_ctl) begin
            rd_byte[`SRIF_CTL_RIE]  = s_ff.rie;
            rd_byte[`SRIF_CTL_SRS]  = 1'b0;
            rd_byte[`SRIF_CTL_MSTR] = s_ff.mstr;
            rd_byte[`SRIF_CTL_CPOL] = s_ff.cpol;
            rd_byte[`SRIF_CTL_CPHA] = s_ff.cpha;
            rd_byte[`SRIF_CTL_WOM]  = s_ff.wom;
            rd_byte[`SRIF_CTL_EN]   = s_ff.en;
            rd_byte[`SRIF_CTL_TIE]  = s_ff.tie;
        end else if (hit_sts) begin
            rd_byte[`SRIF_STS_RXF]  = s_ff.rxf;
            rd_byte[`SRIF_STS_ERIE] = s_ff.erie;
            rd_byte[`SRIF_STS_OVF]  = s_ff.ovf;
            rd_byte[`SRIF_STS_MODE_FAULT_FLAG] = s_ff.mode_fault_flag;
            rd_byte[`SRIF_STS_TXE]  = s_ff.txe;
            rd_byte[`SRIF_STS_MFEN] = s_ff.mfen;
            rd_byte[`SRIF_STS_SPR_HI:`SRIF_STS_SPR_LO] = s_ff.spr;
        end else if (hit_dat) begin
            rd_byte = s_ff.rxbuf;
        end
    end

    // zero wait state slave; unmapped addresses answer with an error
    always_comb begin
        apb_rsp.prdata  = {24'h00_0000, rd_byte};
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = acc && !(hit_ctl || hit_sts || hit_dat);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic       wr;        // write accepted this cycle
    logic       rd;        // read accepted this cycle
    logic       edge_ev;   // serial clock edge this cycle
    logic       lead;      // edge leaves the idle level
    logic       drive;     // edge that shifts data out
    logic       capture;   // edge that samples data in
    logic       din;       // incoming data pin
    logic       done;      // last edge of the byte
    logic       sel;       // slave selected
    logic [7:0] rx_word;   // incoming byte after this edge

    // later statements override earlier ones, so the order is priority:
    // software clears, hardware sets, the master fault, and last the
    // partial reset of a disabled module
    always_comb begin
        nxt_s   = s_ff;
        wr      = acc && apb_req.pwrite;
        rd      = acc && !apb_req.pwrite;
        edge_ev = 1'b0;
        lead    = 1'b0;
        din     = s_ff.mstr ? pin_in.miso : pin_in.mosi;
        sel     = !s_ff.mstr && !pin_in.ss_n;
        nxt_s.ss_prev   = pin_in.ss_n;
        nxt_s.sclk_prev = pin_in.sclk;

        // software side: arming reads come first so flag sets below win
        if (rd && hit_sts) begin
            nxt_s.arm_rx   = s_ff.rxf || s_ff.ovf;
            nxt_s.arm_mode_fault_flag = s_ff.mode_fault_flag;
        end
        if (rd && hit_dat && s_ff.arm_rx) begin
            nxt_s.rxf    = 1'b0;
            nxt_s.ovf    = 1'b0;
            nxt_s.arm_rx = 1'b0;
        end
        if (wr && hit_ctl) begin
            nxt_s.rie  = apb_req.pwdata[`SRIF_CTL_RIE];
            nxt_s.mstr = apb_req.pwdata[`SRIF_CTL_MSTR];
            nxt_s.cpol = apb_req.pwdata[`SRIF_CTL_CPOL];
            nxt_s.cpha = apb_req.pwdata[`SRIF_CTL_CPHA];
            nxt_s.wom  = apb_req.pwdata[`SRIF_CTL_WOM];
            nxt_s.en   = apb_req.pwdata[`SRIF_CTL_EN];
            nxt_s.tie  = apb_req.pwdata[`SRIF_CTL_TIE];
            if (s_ff.arm_mode_fault_flag) begin
                nxt_s.mode_fault_flag     = 1'b0;
                nxt_s.arm_mode_fault_flag = 1'b0;
            end
        end
        if (wr && hit_sts) begin
            nxt_s.erie = apb_req.pwdata[`SRIF_STS_ERIE];
            nxt_s.mfen = apb_req.pwdata[`SRIF_STS_MFEN];
            nxt_s.spr  = apb_req.pwdata[`SRIF_STS_SPR_HI:`SRIF_STS_SPR_LO];
        end
        if (wr && hit_dat) begin
            nxt_s.txbuf = apb_req.pwdata[7:0];
            nxt_s.txe   = 1'b0;
        end

        // clock edge detection: divider in master, pin edge in slave
        if (s_ff.st == srif_pkg::SRIF_SHIFT) begin
            if (s_ff.mstr) begin
                if (s_ff.cnt == 7'h00) begin
                    nxt_s.cnt  = half_m1[6:0];
                    nxt_s.sclk = ~s_ff.sclk;
                    edge_ev    = 1'b1;
                    lead       = (s_ff.sclk == s_ff.cpol);
                end else begin
                    nxt_s.cnt = s_ff.cnt - 7'h01;
                end
            end else if (pin_in.sclk != s_ff.sclk_prev) begin
                edge_ev = 1'b1;
                lead    = (pin_in.sclk != s_ff.cpol);
            end
        end
        drive   = edge_ev && (s_ff.cpha ? lead : !lead);
        capture = edge_ev && (s_ff.cpha ? !lead : lead);
        done    = edge_ev && (s_ff.edges == `SRIF_LAST_EDGE);
        rx_word = capture ? {s_ff.rsr[6:0], din} : s_ff.rsr;

        // engine
        unique case (s_ff.st)
            srif_pkg::SRIF_IDLE: begin
                nxt_s.sclk = s_ff.cpol;
                // master starts when a byte waits; slave on select
                // (falling select edge for phase zero)
                if (s_ff.en && ((s_ff.mstr && !s_ff.txe) ||
                        (sel && (s_ff.cpha || s_ff.ss_prev)))) begin
                    nxt_s.st      = srif_pkg::SRIF_SHIFT;
                    nxt_s.txe     = 1'b1;
                    nxt_s.edges   = 4'h0;
                    nxt_s.cnt     = half_m1[6:0];
                    nxt_s.out_bit = s_ff.txbuf[7];
                    nxt_s.sr      = s_ff.cpha ? s_ff.txbuf : {s_ff.txbuf[6:0], 1'b0};
                end
            end
            srif_pkg::SRIF_SHIFT: begin
                if (!s_ff.mstr && pin_in.ss_n) begin
                    // deselected mid byte: drop the byte
                    // (stale bits in rsr shift out during the next byte)
                    nxt_s.st = srif_pkg::SRIF_IDLE;
                    if (s_ff.mfen) begin
                        nxt_s.mode_fault_flag = 1'b1;
                    end
                end else if (edge_ev) begin
                    nxt_s.edges = s_ff.edges + 4'h1;
                    nxt_s.rsr   = rx_word;
                    if (drive && !done) begin
                        nxt_s.out_bit = s_ff.sr[7];
                        nxt_s.sr      = {s_ff.sr[6:0], 1'b0};
                    end
                    // the sixteenth edge ends the byte; a capture on it
                    // is already folded into rx_word
                    if (done) begin
                        nxt_s.st = srif_pkg::SRIF_IDLE;
                        if (s_ff.rxf) begin
                            nxt_s.ovf = 1'b1;
                        end else begin
                            nxt_s.rxbuf = rx_word;
                            nxt_s.rxf   = 1'b1;
                        end
                    end
                end
            end
        endcase

        // a second master pulling select low must not fight our pins
        // master with mode fault enabled sees select fall: fault, and the module drops out
        if (s_ff.en && s_ff.mstr && s_ff.mfen && s_ff.ss_prev && !pin_in.ss_n) begin
            nxt_s.mode_fault_flag = 1'b1;
            nxt_s.en   = 1'b0;
        end

        // partial reset while disabled; control bits and flags other than txe (forced to one) stay
        if (!nxt_s.en) begin
            nxt_s.st    = srif_pkg::SRIF_IDLE;
            nxt_s.txe   = 1'b1;
            nxt_s.sclk  = nxt_s.cpol;
            nxt_s.edges = 4'h0;
            nxt_s.cnt   = 7'h00;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // the reset branch loads only a constant, never another flip-flop
    // whole state in one register, async reset to the constant image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= RST_STATE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // pins and interrupt requests
    // ----------------------------------------------------------------
    logic       m_drv;     // enabled master drives clock and mosi
    logic       s_drv;     // enabled selected slave drives miso
    logic [1:0] p_sclk;    // clock pad {out, oe}
    logic [1:0] p_mosi;    // mosi pad {out, oe}
    logic [1:0] p_miso;    // miso pad {out, oe}

    // wired-or pads only pull low; the high level comes from outside
    // because the internal pull-up is off in that mode
    // pad control from registered state, except the slave miso enable, which follows the select pin
    always_comb begin
        m_drv  = s_ff.en && s_ff.mstr;
        s_drv  = s_ff.en && !s_ff.mstr && !pin_in.ss_n;
        p_sclk = pad((s_ff.st == srif_pkg::SRIF_SHIFT) ? s_ff.sclk : s_ff.cpol,
                     s_ff.wom, m_drv);
        p_mosi = pad(s_ff.out_bit, s_ff.wom, m_drv);
        p_miso = pad(s_ff.out_bit, s_ff.wom, s_drv);
        pin_out.sclk_o    = p_sclk[1];
        pin_out.sclk_oe   = p_sclk[0];
        pin_out.mosi_o    = p_mosi[1];
        pin_out.mosi_oe   = p_mosi[0];
        pin_out.miso_o    = p_miso[1];
        pin_out.miso_oe   = p_miso[0];
        pin_out.pullup_en = !s_ff.wom;
        pin_out.ss_gpio   = !s_ff.en || (s_ff.mstr && !s_ff.mfen);
        irq.rx  = s_ff.rxf && s_ff.rie;
        irq.tx  = s_ff.txe && s_ff.tie;
        irq.err = s_ff.erie && (s_ff.mode_fault_flag || s_ff.ovf);
    end

endmodule

// ===== src/srif_consts.svh
// register map, field positions, reset values and divisor constants
`ifndef SRIF_CONSTS_SVH
`define SRIF_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define SRIF_IDX_CONTROL     8'h1b
`define SRIF_IDX_STATUS      8'h1c
`define SRIF_IDX_DATA        8'h1d
`define SRIF_ADDR_CONTROL    (8'((`SRIF_IDX_CONTROL) * 4))
`define SRIF_ADDR_STATUS     (8'((`SRIF_IDX_STATUS) * 4))
`define SRIF_ADDR_DATA       (8'((`SRIF_IDX_DATA) * 4))
// control_reg field positions
`define SRIF_CTL_RIE         7
`define SRIF_CTL_SRS         6
`define SRIF_CTL_MSTR        5
`define SRIF_CTL_CPOL        4
`define SRIF_CTL_CPHA        3
`define SRIF_CTL_WOM         2
`define SRIF_CTL_EN          1
`define SRIF_CTL_TIE         0
// status_control_reg field positions
`define SRIF_STS_RXF         7
`define SRIF_STS_ERIE        6
`define SRIF_STS_OVF         5
`define SRIF_STS_MODE_FAULT_FLAG        4
`define SRIF_STS_TXE         3
`define SRIF_STS_MFEN        2
`define SRIF_STS_SPR_HI      1
`define SRIF_STS_SPR_LO      0
// reset values
`define SRIF_CTL_RST         8'h28
`define SRIF_STS_RST         8'h08
// baud divisors selected by the rate field
`define SRIF_BD_00           8'h02
`define SRIF_BD_01           8'h08
`define SRIF_BD_10           8'h20
`define SRIF_BD_11           8'h80
// index of the last edge in one byte (16 edges, two per bit)
`define SRIF_LAST_EDGE       4'hf
`endif

// ===== src/srif_pkg.sv
// types shared by the serial register interface
package srif_pkg;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } srif_apb_req_t;
    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } srif_apb_rsp_t;
    // serial pin levels seen by the block
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ss_n;
    } srif_pin_in_t;
    // serial pin drive, enables and pad control
    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic pullup_en;
        logic ss_gpio;
    } srif_pin_out_t;
    // cpu interrupt requests
    typedef struct packed {
        logic rx;
        logic tx;
        logic err;
    } srif_irq_t;
    // shift engine state
    typedef enum logic [1:0] {
        SRIF_IDLE  = 2'b01,
        SRIF_SHIFT = 2'b10
    } srif_xfer_t;
endpackage

// ===== tb/srif_chk.sv
// checker: register map, interrupt gating, pad control and master bit rate
`timescale 1ns/1ps
module srif_chk (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire srif_pkg::srif_apb_req_t apb_req,
    input wire srif_pkg::srif_apb_rsp_t apb_rsp,
    input wire srif_pkg::srif_pin_out_t pin_out,
    input wire srif_pkg::srif_irq_t     irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------
    // shadows
    // ------
    logic       acc;      // access phase
    logic       wr_ctl;   // control write
    logic       rd_sts;   // status read
    logic       edg;      // serial clock change while driven
    logic [7:0] bd;       // divisor of the shadowed rate
    logic [4:0] sh_ff;    // rx irq en, tx irq en, error irq en, rate
    logic [1:0] q_ff;     // last clock level and drive enable
    logic [7:0] gap_ff;   // cycles since last serial clock change
    logic [3:0] tog_ff;   // serial clock changes within the byte
    assign acc    = apb_req.psel && apb_req.penable;
    assign wr_ctl = acc && apb_req.pwrite && apb_req.paddr == 8'h6c;
    assign rd_sts = acc && !apb_req.pwrite && apb_req.paddr == 8'h70;
    assign edg    = pin_out.sclk_o != q_ff[1] && q_ff[0] && pin_out.sclk_oe;
    assign bd     = sh_ff[1:0] == 2'h0 ? 8'h02 : sh_ff[1:0] == 2'h1 ? 8'h08 :
                    sh_ff[1:0] == 2'h2 ? 8'h20 : 8'h80;
    // follow committed writes; the first edge of a byte has no gap to check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff  <= '0;
            q_ff   <= '0;
            gap_ff <= '0;
            tog_ff <= '0;
        end else begin
            q_ff <= {pin_out.sclk_o, pin_out.sclk_oe};
            if (wr_ctl)
                sh_ff[4:3] <= {apb_req.pwdata[7], apb_req.pwdata[0]};
            if (acc && apb_req.pwrite && apb_req.paddr == 8'h70)
                sh_ff[2:0] <= {apb_req.pwdata[6], apb_req.pwdata[1:0]};
            if (edg)
                gap_ff <= 8'h01;
            else if (gap_ff != 8'hff)
                gap_ff <= gap_ff + 8'h01;
            if (!pin_out.sclk_oe)
                tog_ff <= 4'h0;
            else if (edg)
                tog_ff <= tog_ff + 4'h1;
        end
    end
    a_map_error: assert property (acc |-> apb_rsp.pslverr == !(apb_req.paddr inside
        {8'h6c, 8'h70, 8'h74})) else $error("error response does not match map");
    a_ctl_bit_zero: assert property (acc && !apb_req.pwrite && apb_req.paddr == 8'h6c
        |-> apb_rsp.prdata[31:6] == 26'h0 || apb_rsp.prdata[31:6] == 26'h2)
        else $error("control reads nonzero fixed bits");
    a_wired_pullup: assert property (wr_ctl |=> pin_out.pullup_en ==
        !$past(apb_req.pwdata[2])) else $error("pull-up does not follow wired mode");
    a_off_idle: assert property (wr_ctl && !apb_req.pwdata[1] |=>
        !pin_out.sclk_oe && !pin_out.mosi_oe && pin_out.ss_gpio)
        else $error("disabled module still drives pins");
    a_rx_irq: assert property (rd_sts |-> irq.rx == (apb_rsp.prdata[7] && sh_ff[4]))
        else $error("receive interrupt gating wrong");
    a_tx_irq: assert property (rd_sts |-> irq.tx == (apb_rsp.prdata[3] && sh_ff[3]))
        else $error("transmit interrupt gating wrong");
    a_err_irq: assert property (rd_sts |-> irq.err ==
        ((apb_rsp.prdata[5] || apb_rsp.prdata[4]) && sh_ff[2]))
        else $error("error interrupt gating wrong");
    a_master_rate: assert property (edg && tog_ff != 4'h0 |-> gap_ff == bd)
        else $error("serial half period wrong");
    c_overflow: cover property (rd_sts && apb_rsp.prdata[5]);
    c_fault: cover property (rd_sts && apb_rsp.prdata[4]);
    c_byte: cover property (edg && tog_ff == 4'hf && bd == 8'h80);
endmodule
bind srif_spi_regs srif_chk u_srif_chk (
    .pclk    (pclk),
    .presetn (presetn),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .pin_out (pin_out),
    .irq     (irq)
);

// ===== tb/srif_peer.sv
// behavioural serial slave that answers the master one byte per select
`timescale 1ns/1ps
module srif_peer (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;   // outgoing bits, msb on the line
    int         nsh;  // shift edges since select
    initial miso = 1'b0;
    // a new select loads the answer byte
    always @(negedge sel_n) begin
        sh = tx_byte;
        nsh = 0;
    end
    // a released line shows the inverse of its last bit
    always @(sel_n or sh) miso = sel_n ? ~miso : sh[7];
    // same polarity and phase as the master: sample on one edge, shift on the other
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != cpol) ^ cpha)
                rx_byte = {rx_byte[6:0], mosi};
            else begin
                if (!(cpha && nsh == 0))
                    sh = {sh[6:0], ~sh[0]};
                nsh++;
            end
        end
    end
endmodule

// ===== tb/tb.sv
// testbench: register traffic and master transfers against a serial peer
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    srif_pkg::srif_apb_req_t apb_req = '0;
    srif_pkg::srif_apb_rsp_t apb_rsp;
    srif_pkg::srif_pin_in_t pin_in;
    srif_pkg::srif_pin_out_t pin_out;
    srif_pkg::srif_irq_t irq;
    logic ss_n = 1'b1;           // select pin seen by the block
    logic sel_n = 1'b1;          // peer select
    logic cpol = 1'b0;
    logic cpha = 1'b1;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] peer_rx;
    logic peer_miso;
    logic [7:0] b, p, q;         // sent byte, peer byte, kept byte
    int fail_count = 0;
    int checked = 0;
    logic [32:0] exp_q[$];       // expected {pslverr, prdata}
    logic [32:0] msk_q[$];
    string nm_q[$];
    always #10 pclk = ~pclk;
    // released clock and mosi lines float high through pull-ups; a released miso shows the peer
    assign pin_in = '{pin_out.sclk_oe ? pin_out.sclk_o : 1'b1,
                      pin_out.mosi_oe ? pin_out.mosi_o : 1'b1,
                      pin_out.miso_oe ? pin_out.miso_o : peer_miso, ss_n};
    srif_spi_regs u_srif_spi_regs (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .pin_in(pin_in),
        .pin_out(pin_out), .irq(irq));
    srif_peer u_srif_peer (.sclk(pin_in.sclk), .mosi(pin_in.mosi), .sel_n(sel_n),
        .cpol(cpol), .cpha(cpha), .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, 32'(d)};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        xfer(1'b0, a, 8'h00);
    endtask
    task automatic wait_irq(input int k);
        for (int n = 0; n < 6000 && irq[k] !== 1'b1; n++) @(posedge pclk);
        chk("interrupt", 33'h1, 33'(irq[k]));
    endtask
    task automatic send();
        b = 8'($urandom);
        p = 8'($urandom);
        peer_tx <= p;
        sel_n <= 1'b1;
        @(posedge pclk);
        sel_n <= 1'b0;
        xfer(1'b1, 8'h74, b);
        wait_irq(2);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // compare each completed read with the oldest note
    always @(posedge pclk) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite)
            chk(nm_q.pop_front(), exp_q.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(56));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd("control reset", 8'h6c, 33'h28);
        rd("status reset", 8'h70, 33'h08);
        rd("unmapped", 8'h78, 33'h1_0000_0000);
        xfer(1'b1, 8'h6c, 8'hff);
        rd("control fixed bit", 8'h6c, 33'hbf);
        $display("test reset and map done");
        for (int r = 0; r < 4; r++) begin
            cpol <= r[1];
            cpha <= r[0];
            xfer(1'b1, 8'h70, 8'(r));
            xfer(1'b1, 8'h6c, {3'b101, 2'(r), 3'b000});
            xfer(1'b1, 8'h6c, {3'b101, 2'(r), 3'b010});
            send();
            rd("status full", 8'h70, 33'(8'h88 | 8'(r)));
            rd("rx data", 8'h74, 33'(p));
            @(negedge pclk);
            chk("peer byte", 33'(b), 33'(peer_rx));
            chk("rx irq cleared", 33'h0, 33'(irq.rx));
            chk("idle clock", 33'(r[1]), 33'(pin_out.sclk_o));
            chk("select free", 33'h1, 33'(pin_out.ss_gpio));
        end
        $display("test rates and formats done");
        cpol <= 1'b0;
        cpha <= 1'b1;
        xfer(1'b1, 8'h70, 8'h40);
        xfer(1'b1, 8'h6c, 8'ha8);
        xfer(1'b1, 8'h6c, 8'haa);
        send();
        q = p;
        send();
        wait_irq(0);
        chk("peer second byte", 33'(b), 33'(peer_rx));
        rd("overflow status", 8'h70, 33'he8);
        rd("kept byte", 8'h74, 33'(q));
        rd("cleared status", 8'h70, 33'h48);
        $display("test overflow done");
        xfer(1'b1, 8'h70, 8'h44);
        @(negedge pclk);
        chk("select owned", 33'h0, 33'(pin_out.ss_gpio));
        @(posedge pclk);
        ss_n <= 1'b0;
        wait_irq(0);
        rd("fault status", 8'h70, 33'h5c);
        rd("fault disables", 8'h6c, 33'ha8);
        ss_n <= 1'b1;
        xfer(1'b1, 8'h70, 8'h40);
        rd("fault kept", 8'h70, 33'h58);
        xfer(1'b1, 8'h6c, 8'h28);
        rd("fault cleared", 8'h70, 33'h48);
        $display("test mode fault done");
        xfer(1'b1, 8'h6c, 8'h03);
        xfer(1'b1, 8'h74, 8'h5a);
        rd("tx not empty", 8'h70, 33'h40);
        @(negedge pclk);
        chk("slave output off", 33'h0, 33'(pin_out.miso_oe));
        @(posedge pclk);
        ss_n <= 1'b0;
        @(negedge pclk);
        chk("slave output on", 33'h1, 33'(pin_out.miso_oe));
        @(posedge pclk);
        ss_n <= 1'b1;
        rd("slave abort", 8'h70, 33'h48);
        xfer(1'b1, 8'h74, 8'h5a);
        xfer(1'b1, 8'h6c, 8'h01);
        rd("tx empty forced", 8'h70, 33'h48);
        xfer(1'b1, 8'h74, 8'ha5);
        rd("write while off", 8'h70, 33'h48);
        @(negedge pclk);
        chk("tx irq", 33'h1, 33'(irq.tx));
        $display("test slave and disable done");
        tally_and_finish();
    end
endmodule
